// File: common/autoneg_pkg.sv
// Package: register map, reset values and carrier types for base-page regs
package autoneg_pkg;

  // ==========================================================
  // Register map (printed offsets 0x4/0x5 are word indices)
  localparam logic [3:0] ADVERT_IDX = 4'h4;
  localparam logic [3:0] PARTNER_IDX = 4'h5;
  localparam logic [3:0] CTRL_IDX = 4'h6;
  localparam logic [3:0] STATUS_IDX = 4'h7;

  // ==========================================================
  // Field positions
  localparam int TECH_LO = 5;
  localparam int TECH_HI = 7;
  localparam int SEL_LO = 0;
  localparam int SEL_HI = 4;

  // ==========================================================
  // Reset values
  localparam logic [2:0] TECH_RST = 3'h7;
  localparam logic [4:0] SEL_RST = 5'h01;
  localparam logic [15:0] PARTNER_RST = 16'h0000;

  // Control register bits
  localparam int CTL_SWRST = 0;
  localparam int CTL_RESTART = 1;
  localparam int CTL_ANEN = 2;
  localparam int CTL_DUPLEX = 3;
  localparam int CTL_SPDLSB = 4;
  localparam int CTL_SPDMSB = 5;
  localparam int CTL_PD0 = 6;
  localparam int CTL_PD1 = 7;
  localparam logic [7:0] CTL_RST = 8'h04;

  // Advertised abilities handed to the negotiation engine
  typedef struct packed {
    logic gigFull;
    logic gigHalf;
    logic [2:0] tech;
    logic [4:0] selector;
  } advert_t;

  // Received base-page word from the arbiter
  typedef struct packed {
    logic valid;
    logic [15:0] word;
  } rx_page_t;

endpackage

// File: hdl/autoneg_base_page_regs.sv
// Base-page advertisement and partner ability registers on AHB-Lite
`timescale 1ns/100ps

// Overview of operation
// - Advert writes stay pending until soft reset, restart or link loss.
// - A power-down control leaving power-down also applies pending writes.
// - Autoneg off with forced gigabit still runs, gigabit only, per duplex.
// - In forced gigabit the 10/100 and gigabit advertise bits are ignored.
// - Bits 7..5 advertise 100TX-HD, 10T-FD, 10T-HD when 1 and reset to 1.
// - Selector resets to 00001 and keeps its value over software reset.
// - Partner bit 15 is next page; all read-only, cleared by either reset.
// - Partner bit 14 mirrors received acknowledge.
// - Partner bit 13 mirrors received remote fault.
// - Partner bit 11 mirrors asymmetric pause, bit 12 mirrors its bit.
// - Partner bit 10 mirrors pause capability.
// - Partner bits 9..5 mirror the received technology bits.
// - Partner bits 4..0 mirror the received selector, zero after reset.
module autoneg_base_page_regs (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic clkEn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic linkUp,
  input wire autoneg_pkg::rx_page_t rxPage,
  output autoneg_pkg::advert_t advert,
  output logic anRunning
);

  // ==========================================================
  // Bus address phase capture
  logic wrPend_reg;
  logic [3:0] wrIdx_reg;
  logic linkMeta_reg;
  logic linkSync_reg;
  logic linkPrev_reg;
  logic [7:0] ctrl_reg;
  logic [7:0] ctrl_next;
  logic pdPrev0_reg;
  logic pdPrev1_reg;
  logic [2:0] techPend_reg;
  logic [4:0] selPend_reg;
  logic [2:0] techAct_reg;
  logic [4:0] selAct_reg;
  logic [15:0] partner_reg;
  logic [31:0] rdData_reg;

  wire addrPhase = hsel && hready && htrans[1];
  wire [3:0] addrIdx = haddr[5:2];
  wire wrAdvert = wrPend_reg && (wrIdx_reg == autoneg_pkg::ADVERT_IDX);
  wire wrCtrl = wrPend_reg && (wrIdx_reg == autoneg_pkg::CTRL_IDX);

  // ==========================================================
  // Trigger events
  wire swReset = wrCtrl && hwdata[autoneg_pkg::CTL_SWRST];
  wire restart = wrCtrl && hwdata[autoneg_pkg::CTL_RESTART];
  wire linkLost = linkPrev_reg && !linkSync_reg;
  // Leaving power-down on either control bit
  wire pdExit = (pdPrev0_reg && !ctrl_reg[autoneg_pkg::CTL_PD0]) ||
                (pdPrev1_reg && !ctrl_reg[autoneg_pkg::CTL_PD1]);
  wire applyPend = swReset || restart || linkLost || pdExit;

  // Reset and trigger pulses are self-clearing; other bits store
  always_comb begin
    ctrl_next = ctrl_reg;
    if (wrCtrl) begin
      ctrl_next = hwdata[7:0];
    end
    ctrl_next[autoneg_pkg::CTL_SWRST] = 1'b0;
    ctrl_next[autoneg_pkg::CTL_RESTART] = 1'b0;
  end

  // ==========================================================
  // Forced gigabit advertisement
  wire forcedGig = !ctrl_reg[autoneg_pkg::CTL_ANEN] &&
                   ctrl_reg[autoneg_pkg::CTL_SPDMSB] &&
                   !ctrl_reg[autoneg_pkg::CTL_SPDLSB];
  // Negotiation never stops in forced gigabit: it is mandatory there
  assign anRunning = ctrl_reg[autoneg_pkg::CTL_ANEN] || forcedGig;
  assign advert.gigFull = forcedGig && ctrl_reg[autoneg_pkg::CTL_DUPLEX];
  assign advert.gigHalf = forcedGig && !ctrl_reg[autoneg_pkg::CTL_DUPLEX];
  assign advert.tech = forcedGig ? 3'h0 : techAct_reg;
  assign advert.selector = selAct_reg;

  // ==========================================================
  // Read mux
  wire [15:0] advertView = {8'h00, techAct_reg, selAct_reg};
  wire [15:0] statusView = {14'h0000, linkSync_reg, anRunning};
  wire [31:0] rdMux =
    (addrIdx == autoneg_pkg::ADVERT_IDX) ? {16'h0000, advertView} :
    (addrIdx == autoneg_pkg::PARTNER_IDX) ? {16'h0000, partner_reg} :
    (addrIdx == autoneg_pkg::CTRL_IDX) ? {24'h000000, ctrl_reg} :
    (addrIdx == autoneg_pkg::STATUS_IDX) ? {16'h0000, statusView} :
    32'h00000000;

  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = rdData_reg;

  // ==========================================================
  // Bus and control state
  always_ff @(posedge core_clk) begin
    if (rst) begin
      wrPend_reg <= 1'b0;
      wrIdx_reg <= 4'h0;
      rdData_reg <= 32'h00000000;
      ctrl_reg <= autoneg_pkg::CTL_RST;
      pdPrev0_reg <= 1'b0;
      pdPrev1_reg <= 1'b0;
    end else if (clkEn) begin
      wrPend_reg <= addrPhase && hwrite;
      wrIdx_reg <= addrIdx;
      if (addrPhase && !hwrite) begin
        rdData_reg <= rdMux;
      end
      ctrl_reg <= ctrl_next;
      pdPrev0_reg <= ctrl_reg[autoneg_pkg::CTL_PD0];
      pdPrev1_reg <= ctrl_reg[autoneg_pkg::CTL_PD1];
    end
  end

  // Link status from the line side is asynchronous
  always_ff @(posedge core_clk) begin
    if (rst) begin
      linkMeta_reg <= 1'b0;
      linkSync_reg <= 1'b0;
      linkPrev_reg <= 1'b0;
    end else if (clkEn) begin
      linkMeta_reg <= linkUp;
      linkSync_reg <= linkMeta_reg;
      linkPrev_reg <= linkSync_reg;
    end
  end

  // ==========================================================
  // Advertisement: pending copy and active copy
  always_ff @(posedge core_clk) begin
    if (rst) begin
      techPend_reg <= autoneg_pkg::TECH_RST;
      selPend_reg <= autoneg_pkg::SEL_RST;
      techAct_reg <= autoneg_pkg::TECH_RST;
      selAct_reg <= autoneg_pkg::SEL_RST;
    end else if (clkEn) begin
      if (wrAdvert) begin
        techPend_reg <= hwdata[autoneg_pkg::TECH_HI:autoneg_pkg::TECH_LO];
        selPend_reg <= hwdata[autoneg_pkg::SEL_HI:autoneg_pkg::SEL_LO];
      end
      // Whole copy moves at once; a same-cycle write is included
      if (applyPend) begin
        techAct_reg <= wrAdvert ?
          hwdata[autoneg_pkg::TECH_HI:autoneg_pkg::TECH_LO] :
          techPend_reg;
        selAct_reg <= wrAdvert ?
          hwdata[autoneg_pkg::SEL_HI:autoneg_pkg::SEL_LO] :
          selPend_reg;
      end
    end
  end

  // ==========================================================
  // Partner ability: whole received word, bit for bit
  always_ff @(posedge core_clk) begin
    if (rst) begin
      partner_reg <= autoneg_pkg::PARTNER_RST;
    end else if (clkEn) begin
      if (swReset) begin
        partner_reg <= autoneg_pkg::PARTNER_RST;
      end else if (rxPage.valid) begin
        // Bits 15..0: NP, ack, RF, 12, asym, pause, tech, selector
        partner_reg <= rxPage.word;
      end
    end
  end

endmodule

// File: tb/autoneg_base_page_regs_asserts.sv
// Checker for bus replies and advertised abilities
`timescale 1ns/100ps
module autoneg_base_page_regs_asserts (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic clkEn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic hready,
  input wire logic [31:0] hrdata,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire autoneg_pkg::rx_page_t rxPage,
  input wire autoneg_pkg::advert_t advert,
  input wire logic anRunning
);
  // ==========================================================
  // Data-phase tracking
  logic rdPh;
  logic wrPh;
  logic [7:0] addrQ;
  wire taken = hsel & hready & htrans[1] & clkEn;
  wire rdTaken = taken & ~hwrite;
  wire gig = advert.gigFull | advert.gigHalf;
  always_ff @(posedge core_clk) begin
    if (rst) begin
      rdPh <= 1'b0;
      wrPh <= 1'b0;
    end else if (clkEn) begin
      rdPh <= rdTaken;
      wrPh <= taken & hwrite;
      addrQ <= haddr[7:0];
    end
  end
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  sequence advRd; rdPh && addrQ == 8'h10; endsequence
  sequence partRd; rdPh && addrQ == 8'h14; endsequence
  resp_okay_a:
    assert property (hreadyout && !hresp) else $error("reply not okay");
  gig_onehot_a:
    assert property (!(advert.gigFull && advert.gigHalf)) else $error("gig");
  gig_only_a:
    assert property (gig |-> advert.tech == 3'h0 && anRunning)
      else $error("forced gig");
  hw_reset_a:
    assert property ($fell(rst) |-> advert.tech == autoneg_pkg::TECH_RST &&
      advert.selector == autoneg_pkg::SEL_RST && hrdata == 32'h0)
      else $error("reset values");
  adv_rd_a:
    assert property (advRd ##0 !$past(gig) |-> hrdata ==
      {24'h0, $past({advert.tech, advert.selector})}) else $error("adv read");
  part_mirror_a:
    assert property (partRd ##0 ($past(rxPage.valid, 2) && $past(clkEn, 2)
      && !$past(rst, 2) && !$past(wrPh) && !$past(wrPh, 2)) |->
      hrdata == {16'h0, $past(rxPage.word, 2)}) else $error("mirror");
  rd_hold_a:
    assert property (!$past(rdTaken) |-> $stable(hrdata)) else $error("hold");
  rd_hi_zero_a:
    assert property (rdPh |-> hrdata[31:16] == 16'h0) else $error("high");
endmodule
bind autoneg_base_page_regs autoneg_base_page_regs_asserts
  u_autoneg_base_page_regs_asserts (.core_clk, .rst, .clkEn, .hsel, .haddr,
  .htrans, .hwrite, .hready, .hrdata, .hreadyout, .hresp, .rxPage, .advert,
  .anRunning);

// File: tb/testbench.sv
// Self-checking bench for the base-page registers
`timescale 1ns/100ps
module testbench;
  logic core_clk = 1'b0;
  logic rst = 1'b1;
  logic clkEn = 1'b1;
  logic hsel = 1'b1;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic linkUp = 1'b1;
  autoneg_pkg::rx_page_t rxPage = '0;
  logic [31:0] hrdata;
  logic [31:0] rd;
  logic hreadyout;
  logic hresp;
  autoneg_pkg::advert_t advert;
  logic anRunning;
  int err_count = 0;
  int n_checks = 0;
  always #25 core_clk = ~core_clk;
  autoneg_base_page_regs u_autoneg_base_page_regs (.core_clk, .rst, .clkEn,
    .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2), .hwdata,
    .hready(hreadyout), .hrdata, .hreadyout, .hresp, .linkUp, .rxPage,
    .advert, .anRunning);
  // ==========================================================
  // Bus and compare helpers
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic xfer(input logic wr, input logic [7:0] a,
    input logic [31:0] d);
    haddr <= {24'h0, a};
    hwrite <= wr;
    htrans <= 2'h2;
    @(posedge core_clk);
    while (hreadyout !== 1'b1) @(posedge core_clk);
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge core_clk);
    while (hreadyout !== 1'b1) @(posedge core_clk);
    rd = hrdata;
  endtask
  task automatic rdchk(input logic [7:0] a, input logic [31:0] e);
    xfer(1'b0, a, 32'h0);
    chk(rd, e);
  endtask
  task automatic outchk(input logic [5:0] e);
    #1;
    chk({26'h0, advert.gigFull, advert.gigHalf, advert.tech, anRunning},
      {26'h0, e});
  endtask
  // ==========================================================
  // Scenarios
  task automatic t_pending;
    logic [31:0] prev;
    logic [31:0] nv;
    rdchk(8'h10, 32'he1);
    rdchk(8'h40, 32'h0);
    xfer(1'b1, 8'h10, 32'h02);
    rdchk(8'h10, 32'he1);
    xfer(1'b1, 8'h18, 32'h06);
    rdchk(8'h10, 32'h02);
    xfer(1'b1, 8'h10, 32'ha1);
    linkUp <= 1'b0;
    repeat (6) @(posedge core_clk);
    linkUp <= 1'b1;
    rdchk(8'h10, 32'ha1);
    prev = 32'ha1;
    for (int b = 6; b < 8; b++) begin
      nv = {24'h0, b[2:0], 5'h03};
      xfer(1'b1, 8'h10, nv);
      xfer(1'b1, 8'h18, 32'h04 | (32'h1 << b));
      repeat (3) @(posedge core_clk);
      rdchk(8'h10, prev);
      xfer(1'b1, 8'h18, 32'h04);
      repeat (3) @(posedge core_clk);
      rdchk(8'h10, nv);
      prev = nv;
    end
    $display("pending test done");
  endtask
  task automatic t_partner;
    logic [15:0] w;
    rdchk(8'h14, 32'h0);
    for (int i = 0; i < 2; i++) begin
      w = i ? 16'h5a3c : 16'ha5c3;
      rxPage <= {1'b1, w};
      @(posedge core_clk);
      // Word flipped once valid drops, so a stale capture shows
      rxPage <= {1'b0, ~w};
      rdchk(8'h14, {16'h0, w});
    end
    xfer(1'b1, 8'h14, 32'hffff);
    rdchk(8'h14, 32'h5a3c);
    xfer(1'b1, 8'h18, 32'h05);
    rdchk(8'h14, 32'h0);
    rdchk(8'h10, 32'he3);
    $display("partner test done");
  endtask
  task automatic t_forced;
    xfer(1'b1, 8'h18, 32'h28);
    outchk(6'h21);
    xfer(1'b1, 8'h18, 32'h20);
    outchk(6'h11);
    xfer(1'b1, 8'h18, 32'h04);
    outchk(6'h0f);
    rdchk(8'h1c, 32'h3);
    // Frozen clock must drop a received word
    clkEn <= 1'b0;
    rxPage <= {1'b1, 16'hffff};
    @(posedge core_clk);
    rxPage <= {1'b0, 16'h0000};
    clkEn <= 1'b1;
    rdchk(8'h14, 32'h0);
    $display("forced gigabit test done");
  endtask
  task automatic complete_run;
    $display("checks %0d mismatches %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  initial begin
    repeat (4) @(posedge core_clk);
    rst <= 1'b0;
    t_pending;
    t_partner;
    t_forced;
    complete_run;
  end
  initial begin
    #100000;
    err_count++;
    complete_run;
  end
endmodule
